// ### core/dbk_consts.svh
`ifndef DBK_CONSTS_SVH
`define DBK_CONSTS_SVH

// control write field positions (mode pin low)
`define DBK_REG_SEL_BIT        0
`define DBK_SYS_CLEAR_BIT      3
`define DBK_GLOBAL_STANDBY_BIT 4
`define DBK_POWER_N_BIT        5
`define DBK_CODING_BIT     6
`define DBK_WIDTH_BIT      7
`define DBK_CHAN_CLEAR_BIT     3
`define DBK_CHAN_STANDBY_N_BIT 4
`define DBK_SUB_BIT        7
`define DBK_BIAS_LO_BIT    8
`define DBK_BIAS_HI_BIT    9

// byte mode data write control bits
`define DBK_BYTE_SUB_BIT   0
`define DBK_BYTE_LSB_BIT   1

// power-up values
`define DBK_RST_POWER_N    1'h1
`define DBK_RST_GLOBAL_STANDBY 1'h1
`define DBK_RST_CODING     1'h1
`define DBK_RST_WIDTH      1'h0
`define DBK_RST_STANDBY_N  1'h1
`define DBK_RST_CHAN_CLEAR 1'h1
`define DBK_RST_BIAS       2'h0

// clear codes
`define DBK_MAIN_CLEAR_OB  10'h000
`define DBK_MAIN_CLEAR_TC  10'h000
`define DBK_SUB_MID_OB     8'h80
`define DBK_SUB_MID_TC     8'h00

// host apb register offsets
`define DBK_OFS_CMD        8'h00
`define DBK_OFS_CTRL       8'h04
`define DBK_OFS_STATUS     8'h08

// host apb field positions
`define DBK_CMD_ADDR_LSB   10
`define DBK_CMD_MODE_BIT   13
`define DBK_CMD_LOAD_BIT   14
`define DBK_CTRL_CLEAR_BIT 0
`define DBK_CTRL_LOAD_BIT  1
`define DBK_STAT_BUSY_BIT  0
`define DBK_STAT_LOAD_BIT  1

// timing
`define DBK_CLK_NS         50
`define DBK_SETUP_NS       50
`define DBK_WR_LOW_NS      100
`define DBK_HOLD_NS        50
`define DBK_LOAD_LOW_NS    100
`define DBK_CYC(ns)        (((ns) + `DBK_CLK_NS - 1) / `DBK_CLK_NS)
`define DBK_SETUP_CYC      `DBK_CYC(`DBK_SETUP_NS)
`define DBK_WR_LOW_CYC     `DBK_CYC(`DBK_WR_LOW_NS)
`define DBK_HOLD_CYC       `DBK_CYC(`DBK_HOLD_NS)
`define DBK_LOAD_LOW_CYC   `DBK_CYC(`DBK_LOAD_LOW_NS)

`endif

// ### core/dbk_pkg.sv
package dbk_pkg;

    typedef enum logic [1:0] {
        DBK_BIAS_SUPPLY_MID,
        DBK_BIAS_INTERNAL,
        DBK_BIAS_EXTERNAL,
        DBK_BIAS_UNDEFINED
    } dbk_bias_t;

    typedef enum {
        DBK_H_IDLE,
        DBK_H_SETUP,
        DBK_H_STROBE,
        DBK_H_HOLD
    } dbk_host_state_t;

endpackage : dbk_pkg

// ### core/dbk_port_if.sv
`timescale 1ns/10ps
interface dbk_port_if;
    logic       cs_n;
    logic       wr_n;
    logic       mode;
    logic [2:0] addr;
    logic [9:0] data;
    logic       output_load_strobe_n;
    logic       hw_clear_n;

    modport dev
    (
        input cs_n,
        input wr_n,
        input mode,
        input addr,
        input data,
        input output_load_strobe_n,
        input hw_clear_n
    );

    modport host
    (
        output cs_n,
        output wr_n,
        output mode,
        output addr,
        output data,
        output output_load_strobe_n,
        output hw_clear_n
    );
endinterface : dbk_port_if

// ### core/dbk_dev.sv
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "dbk_consts.svh"

// Overview of operation
// - system clear sets mains to coding level
// - system clear leaves sub converters alone
// - two-bit field picks bias source
// - word mode: target bit routes data
// - byte mode: data bit zero picks target
// - channel standby low idles that channel
// - channel clear resets selected main only
// - channel clear acts on load strobe
// - power-on enters system standby
// - system power-up: active, standby set
// - channel power-up: on, clear, supply mid
// - host writes system register first
// - host then configures channels, then data
// - width bit one selects byte loading
// - control writes: bit zero picks register
// - byte data: bit one picks half
// - clear pin clears mains to level
// - clear pin sets subs to midscale
// - power-down low idles reference and converters
// - registers keep contents through power-down
// - standby never stops the reference
// - mode low control, high data
// - width bit zero selects word loading
// - system standby one idles all converters
module dbk_dev
#(
    parameter int NCH = 8
)
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    dbk_port_if.dev                       port,
    output wire logic [NCH-1:0][9:0]      main_code,
    output wire logic [NCH-1:0][7:0]      sub_code,
    output wire logic [NCH-1:0][2:0]      bias_onehot,
    output wire logic [NCH-1:0]           chan_active,
    output wire logic                     ref_active,
    output wire logic                     outputs_grounded,
    output wire logic                     coding_offset_bin,
    output wire logic                     byte_mode
);

    localparam int CW = (NCH == 8) ? 3 : 2;

    generate
        if (NCH != 4 && NCH != 8)
        begin : g_bad_nch
            $error("dbk_dev: NCH must be 4 or 8");
        end
    endgenerate

    typedef struct packed {
        logic                 wr_n_d;
        logic                 load_n_d;
        logic                 byte_mode;
        logic                 coding_ob;
        logic                 power_down_n;
        logic                 global_standby;
        logic [NCH-1:0][1:0]  bias_sel;
        logic [NCH-1:0]       to_sub;
        logic [NCH-1:0]       standby_n;
        logic [NCH-1:0]       clear_control;
        logic [NCH-1:0][9:0]  main_in;
        logic [NCH-1:0][9:0]  main_out;
        logic [NCH-1:0][7:0]  sub_in;
        logic [NCH-1:0][7:0]  sub_out;
        logic [NCH-1:0][2:0]  bias_oh;
        logic [NCH-1:0]       active;
        logic                 ref_on;
        logic                 grounded;
    } dbk_dev_state_t;

    dbk_dev_state_t s_r;
    dbk_dev_state_t s_nxt;

    logic            wr_rise;
    logic            load_now;
    logic [CW-1:0]   ch;

    function automatic logic [9:0] dbk_main_clear(input logic ob);
        dbk_main_clear = ob ? `DBK_MAIN_CLEAR_OB : `DBK_MAIN_CLEAR_TC;
    endfunction : dbk_main_clear

    function automatic logic [7:0] dbk_sub_mid(input logic ob);
        dbk_sub_mid = ob ? `DBK_SUB_MID_OB : `DBK_SUB_MID_TC;
    endfunction : dbk_sub_mid

    function automatic logic [2:0] dbk_bias_dec(input logic [1:0] sel);
        case (dbk_pkg::dbk_bias_t'(sel))
            dbk_pkg::DBK_BIAS_SUPPLY_MID: dbk_bias_dec = 3'h1;
            dbk_pkg::DBK_BIAS_INTERNAL:   dbk_bias_dec = 3'h2;
            dbk_pkg::DBK_BIAS_EXTERNAL:   dbk_bias_dec = 3'h4;
            default:                      dbk_bias_dec = 3'h0;
        endcase
    endfunction : dbk_bias_dec

    // a write lands on the rising edge of the write strobe
    assign wr_rise  = !s_r.wr_n_d && port.wr_n && !port.cs_n;
    // load strobe low at the write edge updates at once, else on its fall
    assign load_now = (wr_rise && !port.output_load_strobe_n)
                    || (s_r.load_n_d && !port.output_load_strobe_n);
    // quad parts decode only the two low address pins
    assign ch       = port.addr[CW-1:0];

    always_comb
    begin
        s_nxt          = s_r;
        s_nxt.wr_n_d   = port.wr_n;
        s_nxt.load_n_d = port.output_load_strobe_n;

        if (wr_rise && !port.mode)
        begin
            if (!port.data[`DBK_REG_SEL_BIT])
            begin
                s_nxt.byte_mode      = port.data[`DBK_WIDTH_BIT];
                s_nxt.coding_ob      = port.data[`DBK_CODING_BIT];
                s_nxt.power_down_n   =
                    port.data[`DBK_POWER_N_BIT];
                s_nxt.global_standby =
                    port.data[`DBK_GLOBAL_STANDBY_BIT];
                if (port.data[`DBK_SYS_CLEAR_BIT])
                begin
                    // sub registers are deliberately left out here
                    for (int i = 0; i < NCH; i++)
                    begin
                        s_nxt.main_in[i]  =
                            dbk_main_clear(s_nxt.coding_ob);
                        s_nxt.main_out[i] =
                            dbk_main_clear(s_nxt.coding_ob);
                    end
                end
            end
            else
            begin
                s_nxt.bias_sel[ch] = {port.data[`DBK_BIAS_HI_BIT],
                                      port.data[`DBK_BIAS_LO_BIT]};
                s_nxt.to_sub[ch]        = port.data[`DBK_SUB_BIT];
                s_nxt.standby_n[ch]     = port.data[`DBK_CHAN_STANDBY_N_BIT];
                s_nxt.clear_control[ch] = port.data[`DBK_CHAN_CLEAR_BIT];
            end
        end
        else if (wr_rise)
        begin
            if (s_r.byte_mode ? port.data[`DBK_BYTE_SUB_BIT]
                              : s_r.to_sub[ch])
            begin
                s_nxt.sub_in[ch] = port.data[9:2];
            end
            else if (!s_r.byte_mode)
            begin
                s_nxt.main_in[ch] = port.data;
            end
            else if (!port.data[`DBK_BYTE_LSB_BIT])
            begin
                s_nxt.main_in[ch][9:2] = port.data[9:2];
            end
            else
            begin
                s_nxt.main_in[ch][1:0] = port.data[3:2];
            end
        end

        if (load_now)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                // a set clear bit replaces the main word at every load
                s_nxt.main_out[i] = s_nxt.clear_control[i]
                    ? dbk_main_clear(s_nxt.coding_ob)
                    : s_nxt.main_in[i];
                s_nxt.sub_out[i]  = s_nxt.sub_in[i];
            end
        end

        // the pin wins over every write and load in the same cycle
        if (!port.hw_clear_n)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                s_nxt.main_in[i]  = dbk_main_clear(s_nxt.coding_ob);
                s_nxt.main_out[i] = dbk_main_clear(s_nxt.coding_ob);
                s_nxt.sub_in[i]   = dbk_sub_mid(s_nxt.coding_ob);
                s_nxt.sub_out[i]  = dbk_sub_mid(s_nxt.coding_ob);
            end
        end

        // power state only gates activity; stored words stay intact
        s_nxt.ref_on   = s_nxt.power_down_n;
        s_nxt.grounded = !s_nxt.power_down_n
                       || s_nxt.global_standby;
        for (int i = 0; i < NCH; i++)
        begin
            s_nxt.active[i]  = s_nxt.power_down_n
                             && !s_nxt.global_standby
                             && s_nxt.standby_n[i];
            s_nxt.bias_oh[i] = dbk_bias_dec(s_nxt.bias_sel[i]);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r                <= '0;
            s_r.wr_n_d         <= 1'h1;
            s_r.load_n_d       <= 1'h1;
            s_r.byte_mode      <= `DBK_RST_WIDTH;
            s_r.coding_ob      <= `DBK_RST_CODING;
            s_r.power_down_n   <= `DBK_RST_POWER_N;
            s_r.global_standby <= `DBK_RST_GLOBAL_STANDBY;
            s_r.bias_sel       <= {NCH{`DBK_RST_BIAS}};
            s_r.standby_n      <= {NCH{`DBK_RST_STANDBY_N}};
            s_r.clear_control  <= {NCH{`DBK_RST_CHAN_CLEAR}};
            s_r.main_in        <= {NCH{`DBK_MAIN_CLEAR_OB}};
            s_r.main_out       <= {NCH{`DBK_MAIN_CLEAR_OB}};
            s_r.sub_in         <= {NCH{`DBK_SUB_MID_OB}};
            s_r.sub_out        <= {NCH{`DBK_SUB_MID_OB}};
            s_r.bias_oh        <= {NCH{3'h1}};
            s_r.ref_on         <= 1'h1;
            s_r.grounded       <= 1'h1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign main_code         = s_r.main_out;
    assign sub_code          = s_r.sub_out;
    assign bias_onehot       = s_r.bias_oh;
    assign chan_active       = s_r.active;
    assign ref_active        = s_r.ref_on;
    assign outputs_grounded  = s_r.grounded;
    assign coding_offset_bin = s_r.coding_ob;
    assign byte_mode         = s_r.byte_mode;

endmodule : dbk_dev

// ### core/dbk_host.sv
`timescale 1ns/10ps
`include "dbk_consts.svh"

module dbk_host
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output wire logic [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr,
    dbk_port_if.host         port
);

    typedef struct packed {
        dbk_pkg::dbk_host_state_t st;
        logic [3:0]               cnt;
        logic [3:0]               load_cnt;
        logic [14:0]              cmd;
        logic                     clear_hold;
        logic                     pready;
        logic [31:0]              prdata;
        logic                     cs_n;
        logic                     wr_n;
        logic                     mode;
        logic [2:0]               addr;
        logic [9:0]               data;
        logic                     load_n;
        logic                     clear_n;
    } dbk_host_state_t;

    dbk_host_state_t s_r;
    dbk_host_state_t s_nxt;

    logic busy;
    logic cmd_hit;
    logic accept;
    logic commit;

    assign busy    = s_r.st != dbk_pkg::DBK_H_IDLE;
    assign cmd_hit = pwrite && paddr == `DBK_OFS_CMD;
    // a command write waits in its access phase until the port is free
    assign accept  = psel && !s_r.pready && !(cmd_hit && busy);
    assign commit  = psel && penable && s_r.pready;

    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.pready = accept;
        if (accept)
        begin
            s_nxt.prdata = 32'h0000_0000;
            if (paddr == `DBK_OFS_CMD)
            begin
                s_nxt.prdata[14:0] = s_r.cmd;
            end
            else if (paddr == `DBK_OFS_CTRL)
            begin
                s_nxt.prdata[`DBK_CTRL_CLEAR_BIT] = s_r.clear_hold;
            end
            else if (paddr == `DBK_OFS_STATUS)
            begin
                s_nxt.prdata[`DBK_STAT_BUSY_BIT] = busy;
                s_nxt.prdata[`DBK_STAT_LOAD_BIT] = s_r.load_cnt != 4'h0;
            end
        end

        if (s_r.load_cnt != 4'h0)
        begin
            s_nxt.load_cnt = s_r.load_cnt - 4'h1;
        end

        if (commit && pwrite && paddr == `DBK_OFS_CTRL)
        begin
            s_nxt.clear_hold = pwdata[`DBK_CTRL_CLEAR_BIT];
            if (pwdata[`DBK_CTRL_LOAD_BIT])
            begin
                // software pulses this after setting a channel clear
                s_nxt.load_cnt = 4'(`DBK_LOAD_LOW_CYC);
            end
        end

        case (s_r.st)
            dbk_pkg::DBK_H_IDLE:
            begin
                s_nxt.cs_n = 1'h1;
                if (commit && cmd_hit)
                begin
                    // sequencing of writes is software's job
                    s_nxt.cmd  = pwdata[14:0];
                    s_nxt.cs_n = 1'h0;
                    s_nxt.mode = pwdata[`DBK_CMD_MODE_BIT];
                    s_nxt.addr = pwdata[`DBK_CMD_ADDR_LSB +: 3];
                    s_nxt.data = pwdata[9:0];
                    s_nxt.cnt  = 4'(`DBK_SETUP_CYC);
                    s_nxt.st   = dbk_pkg::DBK_H_SETUP;
                end
            end
            dbk_pkg::DBK_H_SETUP:
            begin
                s_nxt.cnt = s_r.cnt - 4'h1;
                if (s_r.cnt == 4'h1)
                begin
                    s_nxt.wr_n = 1'h0;
                    s_nxt.cnt  = 4'(`DBK_WR_LOW_CYC);
                    s_nxt.st   = dbk_pkg::DBK_H_STROBE;
                end
            end
            dbk_pkg::DBK_H_STROBE:
            begin
                s_nxt.cnt = s_r.cnt - 4'h1;
                if (s_r.cnt == 4'h1)
                begin
                    s_nxt.wr_n = 1'h1;
                    s_nxt.cnt  = 4'(`DBK_HOLD_CYC);
                    s_nxt.st   = dbk_pkg::DBK_H_HOLD;
                end
            end
            dbk_pkg::DBK_H_HOLD:
            begin
                s_nxt.cnt = s_r.cnt - 4'h1;
                if (s_r.cnt == 4'h1)
                begin
                    s_nxt.cs_n = 1'h1;
                    s_nxt.st   = dbk_pkg::DBK_H_IDLE;
                end
            end
            default:
            begin
                s_nxt.st = dbk_pkg::DBK_H_IDLE;
            end
        endcase

        // synchronous-update option holds the strobe low across the write
        s_nxt.load_n  = !(s_nxt.load_cnt != 4'h0
                      || (s_nxt.st != dbk_pkg::DBK_H_IDLE
                          && s_nxt.cmd[`DBK_CMD_LOAD_BIT]));
        s_nxt.clear_n = !s_nxt.clear_hold;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r        <= '0;
            s_r.st     <= dbk_pkg::DBK_H_IDLE;
            s_r.cs_n   <= 1'h1;
            s_r.wr_n   <= 1'h1;
            s_r.load_n  <= 1'h1;
            s_r.clear_n <= 1'h1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata                    = s_r.prdata;
    assign pready                    = s_r.pready;
    assign pslverr                   = 1'h0;
    assign port.cs_n                 = s_r.cs_n;
    assign port.wr_n                 = s_r.wr_n;
    assign port.mode                 = s_r.mode;
    assign port.addr                 = s_r.addr;
    assign port.data                 = s_r.data;
    assign port.output_load_strobe_n = s_r.load_n;
    assign port.hw_clear_n           = s_r.clear_n;

endmodule : dbk_host

// ### test/dbk_assertions.sv
`timescale 1ns/10ps
module dbk_assertions
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       cs_n,
    input wire logic       wr_n,
    input wire logic       mode,
    input wire logic [2:0] addr,
    input wire logic [9:0] data,
    input wire logic       output_load_strobe_n,
    input wire logic       hw_clear_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cs_frame_len: assert property
        ($fell(cs_n) |-> !cs_n[*4] ##1 cs_n)
        else $error("chip select frame length wrong");
    a_wr_pulse_len: assert property
        ($fell(wr_n) |=> !wr_n ##1 wr_n)
        else $error("write strobe length wrong");
    a_wr_inside_cs: assert property
        (!wr_n |-> !cs_n)
        else $error("write strobe without chip select");
    a_cs_before_wr: assert property
        ($fell(wr_n) |-> !$past(cs_n))
        else $error("no select setup before strobe");
    a_cs_after_wr: assert property
        ($rose(wr_n) |-> !cs_n)
        else $error("select released before strobe end");
    a_bus_held: assert property
        (!cs_n && !$fell(cs_n) |-> $stable(mode) && $stable(addr)
            && $stable(data))
        else $error("mode, address or data moved in frame");
    a_load_min_two: assert property
        ($fell(output_load_strobe_n) |=> !output_load_strobe_n)
        else $error("load strobe shorter than two cycles");
    a_load_bounded: assert property
        (!output_load_strobe_n |-> ##[1:8] output_load_strobe_n)
        else $error("load strobe stuck low");
    a_idle_after_rst: assert property
        ($rose(presetn) |-> cs_n && wr_n && output_load_strobe_n
            && hw_clear_n)
        else $error("pins not idle after reset");

    c_pin_write: cover property ($rose(wr_n) && !cs_n);
    c_load: cover property ($fell(output_load_strobe_n));
    c_hw_clear: cover property ($fell(hw_clear_n));
endmodule : dbk_assertions

// ### test/dac_bank_control_regs_tb.sv
`timescale 1ns/10ps
module dac_bank_control_regs_tb;
    typedef struct { int k; int i; logic [31:0] v; } dbk_note_t;
    logic            pclk, presetn, psel, penable, pwrite, pready;
    logic [7:0]      paddr, chan_active, act, s, h;
    logic [31:0]     pwdata, prdata, rd_v, last_cmd;
    logic [7:0][9:0] main_code;
    logic [7:0][7:0] sub_code;
    logic [7:0][2:0] bias_onehot;
    logic            ref_active, grounded, coding_ob, byte_mode, st;
    logic [9:0]      v;
    logic [1:0]      l;
    int              n_errors = 0;
    int              num_checks = 0;
    int              cyc = 0;
    int              k;
    dbk_note_t       q[$];
    event            chk_ev;

    dbk_port_if dbk_port_if_i();
    dbk_dev #(.NCH(8)) dbk_dev_i
    (
        .pclk(pclk), .presetn(presetn), .port(dbk_port_if_i.dev),
        .main_code(main_code), .sub_code(sub_code),
        .bias_onehot(bias_onehot), .chan_active(chan_active),
        .ref_active(ref_active), .outputs_grounded(grounded),
        .coding_offset_bin(coding_ob), .byte_mode(byte_mode)
    );
    dbk_host dbk_host_i
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(), .port(dbk_port_if_i.host)
    );
    dbk_assertions dbk_assertions_i
    (
        .pclk(pclk), .presetn(presetn), .cs_n(dbk_port_if_i.cs_n),
        .wr_n(dbk_port_if_i.wr_n), .mode(dbk_port_if_i.mode),
        .addr(dbk_port_if_i.addr), .data(dbk_port_if_i.data),
        .output_load_strobe_n(dbk_port_if_i.output_load_strobe_n),
        .hw_clear_n(dbk_port_if_i.hw_clear_n)
    );

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task give_verdict;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // run needs a few hundred cycles; anything far beyond is a hang
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function logic [31:0] seen_of(input int kd, input int i);
        case (kd)
            0: return 32'(main_code[i]);
            1: return 32'(sub_code[i]);
            2: return 32'(bias_onehot[i]);
            3: return 32'(chan_active);
            4: return {28'h0, ref_active, grounded, coding_ob, byte_mode};
            default: return rd_v;
        endcase
    endfunction : seen_of

    initial forever
    begin
        @(chk_ev);
        while (q.size() > 0)
        begin
            dbk_note_t n;
            n = q.pop_front();
            check(seen_of(n.k, n.i), n.v);
        end
    end

    task note(input int kd, input int i, input logic [31:0] val);
        q.push_back('{kd, i, val});
    endtask : note

    // let the edge's updates land before the watcher looks
    task sample;
        #1;
        ->chk_ev;
    endtask : sample

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // look between edges so the flop update cannot race the sample
        @(negedge pclk);
        while (pready !== 1'b1)
            @(negedge pclk);
        rd_v = prdata;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task pin(input logic m, input logic [2:0] a, input logic [9:0] d,
             input logic ld);
        int n;
        last_cmd = {17'h0, ld, m, a, d};
        apb(1'b1, 8'h00, last_cmd);
        n = 0;
        repeat (2) @(posedge pclk);
        do
        begin
            apb(1'b0, 8'h08, 32'h0);
            n++;
        end while (rd_v[0] !== 1'b0 && n < 50);
        repeat (3) @(posedge pclk);
    endtask : pin

    function logic [9:0] sysw(input logic w, c, pwr_n, sb, sc);
        return {2'b0, w, c, pwr_n, sb, sc, 3'b0};
    endfunction : sysw

    function logic [9:0] chw(input logic [1:0] b, input logic sb, sn, cl);
        return {b, sb, 2'b0, sn, cl, 2'b0, 1'b1};
    endfunction : chw

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        void'($urandom(32'h9836535C));
        k = $urandom_range(7);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        note(4, 0, 32'hE);
        note(3, 0, 32'h0);
        note(2, k, 32'h1);
        note(0, k, 32'h0);
        sample();
        pin(1'b0, 3'h0, sysw(0, 0, 1, 0, 0), 1'b0);
        note(4, 0, 32'h8);
        note(3, 0, 32'hFF);
        sample();
        act = 8'hFF;
        for (int b = 0; b < 4; b++)
        begin
            st = 1'($urandom_range(1));
            act[k] = st;
            pin(1'b0, 3'(k), chw(2'(b), 1'b0, st, 1'b0), 1'b0);
            note(2, k, (b == 3) ? 32'h0 : 32'h1 << b);
            note(3, 0, 32'(act));
            sample();
        end
        v = 10'($urandom) | 10'h1;
        s = 8'($urandom);
        pin(1'b1, 3'(k), v, 1'b1);
        note(0, k, 32'(v));
        pin(1'b0, 3'(k), chw(2'h1, 1'b1, st, 1'b0), 1'b0);
        pin(1'b1, 3'(k), {s, 2'($urandom)}, 1'b1);
        note(1, k, 32'(s));
        note(0, k, 32'(v));
        sample();
        pin(1'b0, 3'h0, sysw(0, 0, 1, 0, 1), 1'b0);
        note(0, k, 32'h0);
        note(1, k, 32'(s));
        sample();
        pin(1'b0, 3'(k), chw(2'h1, 1'b0, st, 1'b0), 1'b0);
        pin(1'b1, 3'(k), v, 1'b1);
        pin(1'b0, 3'(k), chw(2'h1, 1'b0, st, 1'b1), 1'b0);
        note(0, k, 32'(v));
        sample();
        apb(1'b1, 8'h04, 32'h2);
        repeat (4) @(posedge pclk);
        note(0, k, 32'h0);
        note(1, k, 32'(s));
        sample();
        pin(1'b0, 3'(k), chw(2'h1, 1'b0, st, 1'b0), 1'b0);
        pin(1'b0, 3'h0, sysw(0, 0, 0, 0, 0), 1'b0);
        note(4, 0, 32'h4);
        note(3, 0, 32'h0);
        sample();
        pin(1'b0, 3'h0, sysw(0, 0, 1, 1, 0), 1'b0);
        note(4, 0, 32'hC);
        note(3, 0, 32'h0);
        sample();
        pin(1'b0, 3'h0, sysw(0, 0, 1, 0, 0), 1'b0);
        note(3, 0, 32'(act));
        note(1, k, 32'(s));
        sample();
        pin(1'b0, 3'h0, sysw(1, 0, 1, 0, 0), 1'b0);
        note(4, 0, 32'h9);
        pin(1'b0, 3'(k), chw(2'h2, 1'b0, st, 1'b0), 1'b0);
        note(2, k, 32'h4);
        h = 8'($urandom);
        l = 2'($urandom);
        s = 8'($urandom);
        pin(1'b1, 3'(k), {h, 2'b00}, 1'b0);
        pin(1'b1, 3'(k), {6'($urandom), l, 2'b10}, 1'b1);
        note(0, k, {22'h0, h, l});
        pin(1'b1, 3'(k), {s, 1'($urandom), 1'b1}, 1'b1);
        note(1, k, 32'(s));
        note(0, k, {22'h0, h, l});
        sample();
        pin(1'b0, 3'h0, sysw(0, 0, 1, 0, 0), 1'b0);
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        note(5, 0, 32'h1);
        repeat (4) @(posedge pclk);
        note(0, k, 32'h0);
        note(1, k, 32'h0);
        sample();
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        note(5, 0, last_cmd);
        sample();
        apb(1'b1, 8'h10, 32'hFFFFFFFF);
        apb(1'b0, 8'h10, 32'h0);
        note(5, 0, 32'h0);
        sample();
        apb(1'b0, 8'h08, 32'h0);
        note(5, 0, 32'h0);
        sample();
        #1;
        give_verdict();
    end
endmodule : dac_bank_control_regs_tb
